// >>> core/wdt_pkg.sv
/*
 * Package for the windowed watchdog: refresh register address, key and
 * read values, option byte field positions, timing constants and states.
 * Assumes the option byte and CPU access addresses are 8 and 16 bits wide.
 */
package wdt_pkg;

    // Register map and refresh protocol.
    localparam logic [15:0] REFRESH_ADDR    = 16'hFF99;
    localparam logic [7:0]  REFRESH_KEY     = 8'hAC;
    localparam logic [7:0]  REFRESH_RD_OFF  = 8'h1A;
    localparam logic [7:0]  REFRESH_RD_ON   = 8'h9A;
    localparam logic [7:0]  OPT_RESET_VAL   = 8'h00;

    // Option byte field positions.
    localparam int OPT_LOCK_BIT = 0;
    localparam int OPT_OVF_LSB  = 1;
    localparam int OPT_EN_BIT   = 4;
    localparam int OPT_WIN_LSB  = 5;

    // Overflow after 2**(OVF_EXP_BASE + code) slow clock periods.
    localparam int OVF_EXP_BASE = 10;
    localparam int CNT_W        = 17;
    localparam int LIM_W        = 18;

    // Exempt windows for data accesses outside the memory area.
    localparam logic [15:0] EXEMPT_A_LO = 16'hFB00;
    localparam logic [15:0] EXEMPT_A_HI = 16'hFFCF;
    localparam logic [15:0] EXEMPT_B_LO = 16'hFFE0;

    // Timing: the slow oscillator is emulated by an enable pulse.
    localparam int CORE_CLK_HZ      = 50_000_000;
    localparam int SLOW_OSC_FREQ_HZ = 264_000;
    localparam int SLOW_DIV_CYCLES  = CORE_CLK_HZ / SLOW_OSC_FREQ_HZ;
    localparam int DIV_W            = 8;
    localparam logic [DIV_W-1:0] SLOW_DIV_LAST = DIV_W'(SLOW_DIV_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_RUN  = 3'b010,
        ST_TRIP = 3'b100
    } wdt_state_t;

endpackage

// >>> core/wdt_core.sv
/*
 * Windowed watchdog timer: counter on the slow oscillator enable, refresh
 * register with key check, window check, illegal fetch/data access check,
 * low-power pause and the watchdog reset cause flag.
 * Assumes a CPU that presents register writes, a bit-manipulation marker,
 * fetch and data addresses synchronous to core_clk, and a reset controller
 * that consumes the one-cycle dog_reset pulse.
 */
// Functional notes
// - Counter runs only on slow oscillator ticks.
// - Byte write of key clears and restarts counter.
// - Write of any other value causes reset.
// - Bit-manipulation write to refresh register causes reset.
// - Bad write while clock stopped resets on restart.
// - Refresh reads return 9A or 1A by enable.
// - Configuration comes from option byte fields.
// - Enable bit gates counting and access detection.
// - Overflow after 2 to (10+n) slow cycles.
// - Overflow without refresh causes reset.
// - First refresh after reset ignores the window.
// - Later refreshes in closed window cause reset.
// - Window code opens last quarter to whole.
// - Refresh timing error at most two slow periods.
// - Refresh in last count still clears counter.
// - Lock bit zero pauses counting in HALT/STOP.
// - Leaving low power resumes from held count.
// - Oscillator stop with lock zero holds count.
// - Fetch outside memory area causes reset.
// - Data access outside area resets, two ranges exempt.
// - Watchdog reset sets the cause flag.
`timescale 1ns/1ns
`default_nettype none

module wdt_core (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  opt_byte,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_bit_wr,
    input  wire logic        bus_rd,
    output logic      [7:0]  bus_rdata,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        data_valid,
    input  wire logic [15:0] data_addr,
    input  wire logic [15:0] mem_area_end,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        slow_osc_halt,
    input  wire logic        flag_clear,
    output logic             dog_reset,
    output logic             dog_reset_flag
);

    wdt_pkg::wdt_state_t          state_reg;
    wdt_pkg::wdt_state_t          state_next;
    logic [7:0]                   opt_reg;
    logic [wdt_pkg::DIV_W-1:0]    div_reg;
    logic [wdt_pkg::CNT_W-1:0]    cnt_reg;
    logic                         first_done_reg;
    logic                         pend_reg;
    logic                         flag_reg;
    logic [7:0]                   rdata_reg;

    logic                         counter_enable_opt;
    logic                         slow_osc_lock;
    logic [2:0]                   ovf_sel;
    logic [1:0]                   open_period_sel;
    logic                         running;
    logic                         osc_run;
    logic                         tick;
    logic                         counting;
    logic [wdt_pkg::LIM_W-1:0]    limit;
    logic [wdt_pkg::CNT_W-1:0]    last_cnt;
    logic [wdt_pkg::LIM_W-1:0]    open_start;
    logic                         closed_win;
    logic                         refresh_wr;
    logic                         bit_fault;
    logic                         val_fault;
    logic                         win_fault;
    logic                         ref_fault;
    logic                         good_refresh;
    logic                         overflow;
    logic                         fetch_fault;
    logic                         data_exempt;
    logic                         data_fault;
    logic                         fire;

    // Option byte decode.
    assign counter_enable_opt = opt_reg[wdt_pkg::OPT_EN_BIT];
    assign slow_osc_lock      = opt_reg[wdt_pkg::OPT_LOCK_BIT];
    assign ovf_sel            = opt_reg[wdt_pkg::OPT_OVF_LSB +: 3];
    assign open_period_sel    = opt_reg[wdt_pkg::OPT_WIN_LSB +: 2];

    assign running = (state_reg == wdt_pkg::ST_RUN);

    // With the lock bit clear, HALT, STOP and a software oscillator stop all
    // remove the watchdog's source clock; the count is merely frozen.
    assign osc_run  = slow_osc_lock | ~(halt_mode | stop_mode | slow_osc_halt);
    assign tick     = osc_run && (div_reg == wdt_pkg::SLOW_DIV_LAST);
    assign counting = running && counter_enable_opt && osc_run;

    // Overflow length and start of the open window.
    assign limit      = wdt_pkg::LIM_W'(1) << (wdt_pkg::OVF_EXP_BASE + int'(ovf_sel));
    assign last_cnt   = wdt_pkg::CNT_W'(limit - wdt_pkg::LIM_W'(1));
    assign open_start = wdt_pkg::LIM_W'((limit >> 2) * (2'd3 - open_period_sel));
    assign closed_win = wdt_pkg::LIM_W'(cnt_reg) < open_start;

    // Refresh register accesses. Faults are only armed when enabled.
    assign refresh_wr   = running && counter_enable_opt && bus_wr
                          && (bus_addr == wdt_pkg::REFRESH_ADDR);
    assign bit_fault    = refresh_wr && bus_bit_wr;
    assign val_fault    = refresh_wr && !bus_bit_wr
                          && (bus_wdata != wdt_pkg::REFRESH_KEY);
    assign win_fault    = refresh_wr && !bus_bit_wr
                          && (bus_wdata == wdt_pkg::REFRESH_KEY)
                          && first_done_reg && closed_win;
    assign ref_fault    = bit_fault | val_fault | win_fault;
    assign good_refresh = refresh_wr && !ref_fault;

    // A refresh landing on the final count beats the overflow.
    assign overflow = counting && tick && (cnt_reg == last_cnt) && !good_refresh;

    // Illegal memory accesses; the area is taken to start at zero.
    assign fetch_fault = running && counter_enable_opt && fetch_valid
                         && (fetch_addr >= mem_area_end);
    assign data_exempt = ((data_addr >= wdt_pkg::EXEMPT_A_LO)
                          && (data_addr <= wdt_pkg::EXEMPT_A_HI))
                         || (data_addr >= wdt_pkg::EXEMPT_B_LO);
    assign data_fault  = running && counter_enable_opt && data_valid
                         && (data_addr >= mem_area_end) && !data_exempt;

    // Refresh faults wait for the source clock; the rest act at once.
    assign fire = running && (overflow || fetch_fault || data_fault
                  || ((ref_fault || pend_reg) && osc_run));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            wdt_pkg::ST_LOAD: begin
                state_next = wdt_pkg::ST_RUN;
            end
            wdt_pkg::ST_RUN: begin
                if (fire) begin
                    state_next = wdt_pkg::ST_TRIP;
                end
            end
            wdt_pkg::ST_TRIP: begin
                state_next = wdt_pkg::ST_LOAD;
            end
            default: begin
                state_next = wdt_pkg::ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= wdt_pkg::ST_LOAD;
        end else begin
            state_reg <= state_next;
        end
    end

    // The option byte is sampled after every reset release, including the
    // block's own trip, so a changed option byte takes effect there.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            opt_reg <= wdt_pkg::OPT_RESET_VAL;
        end else if (state_reg == wdt_pkg::ST_LOAD) begin
            opt_reg <= opt_byte;
        end
    end

    // The prescaler is not cleared by a refresh, which is where the
    // refresh-to-overflow error of up to a slow period or two comes from.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_reg <= '0;
        end else if (state_reg == wdt_pkg::ST_LOAD) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= '0;
        end else if (osc_run) begin
            div_reg <= div_reg + wdt_pkg::DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
        end else if (state_reg != wdt_pkg::ST_RUN) begin
            cnt_reg <= '0;
        end else if (good_refresh) begin
            cnt_reg <= '0;
        end else if (counting && tick) begin
            cnt_reg <= cnt_reg + wdt_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            first_done_reg <= 1'b0;
        end else if (state_reg == wdt_pkg::ST_LOAD) begin
            first_done_reg <= 1'b0;
        end else if (good_refresh) begin
            first_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend_reg <= 1'b0;
        end else if (state_reg != wdt_pkg::ST_RUN) begin
            pend_reg <= 1'b0;
        end else if (ref_fault && !osc_run) begin
            pend_reg <= 1'b1;
        end
    end

    // The cause flag survives the block's own trip; only the external reset
    // and software clear it. A trip in the clearing cycle keeps it set.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flag_reg <= 1'b0;
        end else if (state_reg == wdt_pkg::ST_TRIP) begin
            flag_reg <= 1'b1;
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else if (bus_rd && (bus_addr == wdt_pkg::REFRESH_ADDR)) begin
            rdata_reg <= counter_enable_opt ? wdt_pkg::REFRESH_RD_ON
                                            : wdt_pkg::REFRESH_RD_OFF;
        end else if (bus_rd) begin
            rdata_reg <= '0;
        end
    end

    assign bus_rdata      = rdata_reg;
    assign dog_reset      = (state_reg == wdt_pkg::ST_TRIP);
    assign dog_reset_flag = flag_reg;

    // Checks.

    property p_refresh_clears;
        @(posedge core_clk) disable iff (reset)
        (good_refresh && !fire) |=> (cnt_reg == '0) && running;
    endproperty
    a_refresh_clears: assert property (p_refresh_clears)
        else $error("Valid refresh did not clear the counter.");

    property p_bad_value;
        @(posedge core_clk) disable iff (reset)
        (val_fault && osc_run) |=> dog_reset ##1 !dog_reset;
    endproperty
    a_bad_value: assert property (p_bad_value)
        else $error("Wrong refresh value did not trip once.");

    property p_bit_write;
        @(posedge core_clk) disable iff (reset)
        (bit_fault && osc_run) |=> dog_reset;
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("Bit write to refresh register did not trip.");

    property p_pending_waits;
        @(posedge core_clk) disable iff (reset)
        (running && ref_fault && !osc_run && !overflow && !fetch_fault && !data_fault)
            |=> !dog_reset ##0 pend_reg;
    endproperty
    a_pending_waits: assert property (p_pending_waits)
        else $error("Fault with stopped source clock was not held.");

    property p_pending_fires;
        @(posedge core_clk) disable iff (reset)
        (running && pend_reg && osc_run) |=> dog_reset;
    endproperty
    a_pending_fires: assert property (p_pending_fires)
        else $error("Held fault did not trip when the clock resumed.");

    property p_read_value;
        @(posedge core_clk) disable iff (reset)
        (bus_rd && (bus_addr == wdt_pkg::REFRESH_ADDR) && state_reg != wdt_pkg::ST_LOAD)
            |=> bus_rdata == ($past(counter_enable_opt) ? 8'h9A : 8'h1A);
    endproperty
    a_read_value: assert property (p_read_value)
        else $error("Refresh register read returned the wrong value.");

    property p_disabled_still;
        @(posedge core_clk) disable iff (reset)
        (running && !counter_enable_opt) |=> (cnt_reg == '0) && !dog_reset;
    endproperty
    a_disabled_still: assert property (p_disabled_still)
        else $error("Disabled watchdog counted or tripped.");

    property p_overflow_trips;
        @(posedge core_clk) disable iff (reset)
        (counting && tick && (cnt_reg == last_cnt) && !good_refresh)
            |=> dog_reset ##1 (state_reg == wdt_pkg::ST_LOAD);
    endproperty
    a_overflow_trips: assert property (p_overflow_trips)
        else $error("Overflow did not trip the watchdog reset.");

    property p_closed_window;
        @(posedge core_clk) disable iff (reset)
        (refresh_wr && !bus_bit_wr && bus_wdata == 8'hAC && first_done_reg
         && closed_win && osc_run) |=> dog_reset;
    endproperty
    a_closed_window: assert property (p_closed_window)
        else $error("Refresh in closed window did not trip.");

    property p_first_free;
        @(posedge core_clk) disable iff (reset)
        (refresh_wr && !bus_bit_wr && bus_wdata == 8'hAC && !first_done_reg
         && !fetch_fault && !data_fault && !pend_reg) |=> !dog_reset && first_done_reg;
    endproperty
    a_first_free: assert property (p_first_free)
        else $error("First refresh was refused.");

    property p_low_power_hold;
        @(posedge core_clk) disable iff (reset)
        (running && !slow_osc_lock && (halt_mode || stop_mode || slow_osc_halt)
         && !good_refresh) |=> $stable(cnt_reg);
    endproperty
    a_low_power_hold: assert property (p_low_power_hold)
        else $error("Counter moved while its clock was stopped.");

    property p_mem_fault;
        @(posedge core_clk) disable iff (reset)
        (fetch_fault || data_fault) |=> dog_reset;
    endproperty
    a_mem_fault: assert property (p_mem_fault)
        else $error("Illegal memory access did not trip.");

    property p_flag_set;
        @(posedge core_clk) disable iff (reset)
        dog_reset |=> dog_reset_flag [*2];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Watchdog reset did not set the cause flag.");

    c_overflow: cover property (@(posedge core_clk) disable iff (reset)
        overflow ##1 dog_reset);
    c_open_refresh: cover property (@(posedge core_clk) disable iff (reset)
        good_refresh && first_done_reg && !closed_win);
    c_pending: cover property (@(posedge core_clk) disable iff (reset)
        pend_reg ##[1:50] dog_reset);
    c_last_count: cover property (@(posedge core_clk) disable iff (reset)
        good_refresh && tick && (cnt_reg == last_cnt));

endmodule // wdt_core

`default_nettype wire

// >>> bench/wdt_cpu_model.sv
/*
 * CPU-side model of the watchdog: refresh writes and reads, fetches, data
 * accesses, low-power levels and the cause flag clear.
 * Assumes tb_top supplies core_clk and calls the tasks from one process.
 */
`timescale 1ns/1ns
`default_nettype none

module wdt_cpu_model (
    input  wire logic        core_clk,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_wr,
    output logic             bus_bit_wr,
    output logic             bus_rd,
    output logic             fetch_valid,
    output logic      [15:0] fetch_addr,
    output logic             data_valid,
    output logic      [15:0] data_addr,
    output logic      [15:0] mem_area_end,
    output logic             halt_mode,
    output logic             stop_mode,
    output logic             slow_osc_halt,
    output logic             flag_clear
);
    initial begin
        {bus_addr, bus_wdata, fetch_addr, data_addr} = '0;
        {bus_wr, bus_bit_wr, bus_rd, fetch_valid, data_valid} = '0;
        {halt_mode, stop_mode, slow_osc_halt, flag_clear} = '0;
        mem_area_end = 16'h8000;
    end

    // Kinds: 0 byte write, 1 bit write, 2 read, 3 fetch, 4 data access.
    task automatic acc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr    <= a;
        bus_wdata   <= d;
        bus_wr      <= (k < 3'd2);
        bus_bit_wr  <= (k == 3'd1);
        bus_rd      <= (k == 3'd2);
        fetch_valid <= (k == 3'd3);
        fetch_addr  <= a;
        data_valid  <= (k == 3'd4);
        data_addr   <= a;
        @(posedge core_clk);
        {bus_wr, bus_bit_wr, bus_rd, fetch_valid, data_valid} <= '0;
        // Released lines show the inverse so stale values cannot match.
        bus_wdata   <= ~d;
        bus_addr    <= ~a;
        fetch_addr  <= ~a;
        data_addr   <= ~a;
    endtask

    task automatic lp(input logic [2:0] m);
        @(posedge core_clk);
        {halt_mode, stop_mode, slow_osc_halt} <= m;
    endtask

    task automatic clr();
        @(posedge core_clk);
        flag_clear <= 1'b1;
        @(posedge core_clk);
        flag_clear <= 1'b0;
    endtask
endmodule // wdt_cpu_model

`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking bench for wdt_core with a CPU model on the bus side.
 * Assumes the option byte is fixed while reset is applied.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    typedef struct packed {logic rst; logic [7:0] val;} wdt_exp_t;
    localparam logic [15:0] RA = wdt_pkg::REFRESH_ADDR;
    localparam logic [7:0]  KY = wdt_pkg::REFRESH_KEY;
    logic core_clk, reset, bus_wr, bus_bit_wr, bus_rd, fetch_valid, data_valid;
    logic halt_mode, stop_mode, slow_osc_halt, flag_clear, dog_reset, dog_reset_flag;
    logic [7:0]  opt_byte, bus_wdata, bus_rdata, v;
    logic [15:0] bus_addr, fetch_addr, data_addr, mem_area_end;
    logic        rd_seen;
    int          failures, checked, cyc, i;
    wdt_exp_t    exp_q[$];
    wdt_exp_t    e;

    wdt_core u_dut (.core_clk(core_clk), .reset(reset), .opt_byte(opt_byte),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_bit_wr(bus_bit_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .data_valid(data_valid),
        .data_addr(data_addr), .mem_area_end(mem_area_end), .halt_mode(halt_mode),
        .stop_mode(stop_mode), .slow_osc_halt(slow_osc_halt), .flag_clear(flag_clear),
        .dog_reset(dog_reset), .dog_reset_flag(dog_reset_flag));

    wdt_cpu_model u_cpu (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_rd(bus_rd),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .data_valid(data_valid),
        .data_addr(data_addr), .mem_area_end(mem_area_end), .halt_mode(halt_mode),
        .stop_mode(stop_mode), .slow_osc_halt(slow_osc_halt), .flag_clear(flag_clear));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        checked++;
        if (s !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic exp_rst();
        exp_q.push_back('{1'b1, 8'h00});
    endtask

    task automatic exp_rd(input logic [7:0] x);
        exp_q.push_back('{1'b0, x});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic boot(input logic [7:0] o);
        @(posedge core_clk);
        reset    <= 1'b1;
        opt_byte <= o;
        idle(4);
        reset <= 1'b0;
        idle(3);
    endtask

    task automatic end_test(input string n);
        idle(10);
        chk("pending", 8'h00, 8'(exp_q.size()));
        $display("test %s done", n);
    endtask

    // Every reset pulse and every read answer must match the oldest note.
    always @(posedge core_clk) begin
        rd_seen <= bus_rd;
        cyc++;
        if (cyc == 8000) begin
            failures++;
            final_report();
        end
        if (dog_reset === 1'b1 || rd_seen === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected", 8'h00, 8'h01);
            else begin
                e = exp_q.pop_front();
                if (dog_reset === 1'b1) chk("reset", {7'd0, e.rst}, 8'h01);
                else chk("rdata", e.val, bus_rdata);
            end
        end
    end

    initial begin
        reset = 1'b1;
        opt_byte = 8'h78;
        rd_seen = 1'b0;
        void'($urandom(23730));
        boot(8'h78);
        exp_rd(wdt_pkg::REFRESH_RD_ON);
        u_cpu.acc(3'd2, RA, 8'h00);
        u_cpu.acc(3'd0, RA, KY);
        u_cpu.acc(3'd0, RA, KY);
        end_test("refresh");
        for (i = 0; i < 3; i++) begin
            v = 8'($urandom);
            if (v == KY) v = 8'h55;
            exp_rst();
            u_cpu.acc(3'd0, RA, v);
            idle(4);
            chk("flag", 8'h01, {7'd0, dog_reset_flag});
            u_cpu.clr();
            idle(4);
            chk("flag clear", 8'h00, {7'd0, dog_reset_flag});
        end
        exp_rst();
        u_cpu.acc(3'd1, RA, KY);
        idle(8);
        end_test("bad writes");
        exp_rst();
        u_cpu.acc(3'd3, 16'h8000 + 16'($urandom % 32'h7000), 8'h00);
        idle(8);
        u_cpu.acc(3'd4, 16'hFB00 + 16'($urandom % 32'h04D0), 8'h00);
        u_cpu.acc(3'd4, 16'hFFE0 + 16'($urandom % 32'h0020), 8'h00);
        u_cpu.acc(3'd4, 16'($urandom % 32'h8000), 8'h00);
        exp_rst();
        u_cpu.acc(3'd4, 16'h8000 + 16'($urandom % 32'h7B00), 8'h00);
        idle(8);
        end_test("memory");
        boot(8'h50);
        u_cpu.acc(3'd0, RA, KY);
        exp_rst();
        u_cpu.acc(3'd0, RA, KY);
        idle(8);
        end_test("window");
        boot(8'h78);
        u_cpu.lp(3'b001);
        u_cpu.acc(3'd0, RA, 8'h55);
        idle(400);
        exp_rst();
        u_cpu.lp(3'b000);
        idle(200);
        boot(8'h79);
        u_cpu.lp(3'b111);
        exp_rst();
        u_cpu.acc(3'd1, RA, KY);
        idle(8);
        u_cpu.lp(3'b000);
        end_test("low power");
        boot(8'h60);
        exp_rd(wdt_pkg::REFRESH_RD_OFF);
        u_cpu.acc(3'd2, RA, 8'h00);
        u_cpu.acc(3'd0, RA, 8'h55);
        u_cpu.acc(3'd3, 16'hA000, 8'h00);
        end_test("disabled");
        final_report();
    end
endmodule // tb_top

`default_nettype wire
